/* rtl/hbg_top.sv */
// three-channel gate logic with undervoltage and overcurrent shutdown
`timescale 1ns/1ps
module hbg_top #(
	parameter int CH          = hbg_pkg::CHANNELS,
	parameter int RESTART_CYC = hbg_pkg::RESTART_CYC_DEFAULT,
	parameter int FILTER_CYC  = hbg_pkg::GLITCH_FILTER_CYC
) (
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic          enable_in,
	input  wire logic [CH-1:0] low_cmd_n,
	input  wire logic [CH-1:0] high_side_cmd_n,
	input  wire logic          main_uv_in,
	input  wire logic [CH-1:0] bootstrap_supply_uv,
	input  wire logic          overcurrent_sense_in,
	input  wire logic          shutdown_timer_pin_low,
	output logic      [CH-1:0] low_gate_out,
	output logic      [CH-1:0] high_gate_out,
	output logic               fault_flag_o,
	output logic               fault_flag_oe,
	output logic               shutdown_timer_pin_o,
	output logic               shutdown_timer_pin_oe
);
	localparam int SYNC_W = 3 * CH + 4;
	logic [SYNC_W-1:0]         sync1_r;
	logic [SYNC_W-1:0]         sync2_r;
	logic [CH-1:0]             lo_s;
	logic [CH-1:0]             hi_s;
	logic [CH-1:0]             boot_s;
	logic                      en_s;
	logic                      uv_s;
	logic                      oc_s;
	logic                      pin_low_s;
	logic [hbg_pkg::CNT_W-1:0] filt_cnt_r;
	logic                      oc_filt;
	logic [hbg_pkg::CNT_W-1:0] restart_cnt_r;
	hbg_pkg::hbg_sd_state_t    sd_r;
	logic                      allow;

	// every outside level except rst crosses two flops before use
	always_ff @(posedge clock) begin
		if (rst) begin
			sync1_r <= {SYNC_W{1'b1}};
			sync2_r <= {SYNC_W{1'b1}};
		end else begin
			sync1_r <= {low_cmd_n, high_side_cmd_n, bootstrap_supply_uv, enable_in,
				main_uv_in, overcurrent_sense_in, shutdown_timer_pin_low}; // RL21
			sync2_r <= sync1_r;
		end
	end

	assign lo_s      = sync2_r[SYNC_W-1 -: CH];
	assign hi_s      = sync2_r[SYNC_W-1-CH -: CH];
	assign boot_s    = sync2_r[SYNC_W-1-2*CH -: CH];
	assign en_s      = sync2_r[3] && !rst;
	assign uv_s      = sync2_r[2] || rst;
	assign oc_s      = sync2_r[1] && !uv_s; // RL17
	assign pin_low_s = sync2_r[0];
	assign oc_filt   = filt_cnt_r >= hbg_pkg::CNT_W'(FILTER_CYC);

	// pulses shorter than the filter count never reach the latch
	always_ff @(posedge clock) begin
		if (rst || !oc_s)
			filt_cnt_r <= '0; // RL12
		else if (!oc_filt)
			filt_cnt_r <= filt_cnt_r + 1'b1; // RL12 RL19
	end

	// shutdown sequence: discharge, then restart count, then run
	always_ff @(posedge clock) begin
		if (rst) begin
			sd_r          <= hbg_pkg::HBG_RUN;
			restart_cnt_r <= '0;
		end else begin
			unique case (sd_r)
				hbg_pkg::HBG_RUN: begin
					if (oc_filt)
						sd_r <= hbg_pkg::HBG_DISCHG; // RL13 RL14
				end
				hbg_pkg::HBG_DISCHG: begin
					restart_cnt_r <= '0;
					if (!oc_s && pin_low_s)
						sd_r <= hbg_pkg::HBG_RESTART; // RL16
				end
				hbg_pkg::HBG_RESTART: begin
					if (oc_filt)
						sd_r <= hbg_pkg::HBG_DISCHG;
					else if (restart_cnt_r >= hbg_pkg::CNT_W'(RESTART_CYC - 1))
						sd_r <= hbg_pkg::HBG_RUN; // RL15 RL20
					else
						restart_cnt_r <= restart_cnt_r + 1'b1; // RL20
				end
			endcase
		end
	end

	// fault flag is output only; allow is built without it
	assign allow = en_s && !uv_s && sd_r == hbg_pkg::HBG_RUN && !oc_filt; // RL1 RL7 RL13 RL18

	for (genvar i = 0; i < CH; i++) begin : g_ch
		hbg_channel #(
			.DEAD_CYC(hbg_pkg::DEAD_INTERVAL_CYC)
		) u_ch (
			.clock          (clock),
			.rst            (rst),
			.allow          (allow),
			.low_cmd_n      (lo_s[i]),
			.high_side_cmd_n(hi_s[i]),
			.boot_uv        (boot_s[i]),
			.low_gate_out   (low_gate_out[i]),
			.high_gate_out  (high_gate_out[i])
		);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			fault_flag_o          <= 1'b0;
			fault_flag_oe         <= 1'b0;
			shutdown_timer_pin_o  <= 1'b0;
			shutdown_timer_pin_oe <= 1'b0;
		end else begin
			fault_flag_o          <= 1'b0;
			fault_flag_oe         <= uv_s || oc_filt || sd_r != hbg_pkg::HBG_RUN; // RL9 RL14 RL15
			shutdown_timer_pin_o  <= 1'b0;
			shutdown_timer_pin_oe <= oc_filt && sd_r == hbg_pkg::HBG_RUN
				|| sd_r == hbg_pkg::HBG_DISCHG; // RL14 RL16
		end
	end

	sequence oc_trigger_s;
		sd_r == hbg_pkg::HBG_RUN && oc_filt;
	endsequence

	sequence shut_s;
		fault_flag_oe && shutdown_timer_pin_oe && low_gate_out == '0 && high_gate_out == '0;
	endsequence

	sequence restart_done_s;
		sd_r == hbg_pkg::HBG_RESTART ##1 sd_r == hbg_pkg::HBG_RUN;
	endsequence

	sequence retrip_s;
		sd_r == hbg_pkg::HBG_RESTART && oc_filt;
	endsequence

	sequence discharge_wait_s;
		sd_r == hbg_pkg::HBG_DISCHG && (oc_s || !pin_low_s);
	endsequence

	trip_shutdown_a: assert property (@(posedge clock) disable iff (rst) // RL13
		oc_trigger_s |=> shut_s) else $error("trip not shut down");

	trip_fault_a: assert property (@(posedge clock) disable iff (rst) // RL14
		oc_trigger_s |=> fault_flag_oe && shutdown_timer_pin_oe) else $error("no fault");

	uv_outputs_a: assert property (@(posedge clock) disable iff (rst) // RL7
		uv_s |=> low_gate_out == '0 && high_gate_out == '0) else $error("gate in uv");

	uv_fault_a: assert property (@(posedge clock) disable iff (rst) // RL9
		uv_s |=> fault_flag_oe) else $error("fault free in uv");

	uv_no_trip_a: assert property (@(posedge clock) disable iff (rst) // RL17
		uv_s |-> filt_cnt_r == '0) else $error("comparator active in uv");

	enable_off_a: assert property (@(posedge clock) disable iff (rst) // RL1
		!en_s |=> low_gate_out == '0 && high_gate_out == '0) else $error("gate w/o enable");

	discharge_hold_a: assert property (@(posedge clock) disable iff (rst) // RL16
		discharge_wait_s |=> shutdown_timer_pin_oe)
		else $error("discharge stopped early");

	release_a: assert property (@(posedge clock) disable iff (rst) // RL15
		sd_r == hbg_pkg::HBG_RUN && !uv_s && !oc_filt |=> !fault_flag_oe)
		else $error("fault not released");

	// watchers below re-derive timing on their own, so a wrong
	// datapath counter cannot hide behind a copy of itself
	logic [hbg_pkg::CNT_W-1:0] oc_run_r;
	logic [hbg_pkg::CNT_W-1:0] restart_len_r;

	// length of the unbroken synced overcurrent level, saturating
	always_ff @(posedge clock) begin
		if (rst || !oc_s)
			oc_run_r <= '0;
		else if (oc_run_r != '1)
			oc_run_r <= oc_run_r + 1'b1;
	end

	// cycles spent in the restart phase so far
	always_ff @(posedge clock) begin
		if (rst || sd_r != hbg_pkg::HBG_RESTART)
			restart_len_r <= '0;
		else if (restart_len_r != '1)
			restart_len_r <= restart_len_r + 1'b1;
	end

	state_legal_a: assert property (@(posedge clock) disable iff (rst)
		$onehot(sd_r)) else $error("shutdown state not one-hot");

	filter_min_a: assert property (@(posedge clock) disable iff (rst) // RL12 RL19
		oc_filt |-> oc_run_r >= hbg_pkg::CNT_W'(FILTER_CYC))
		else $error("trip before filter time");

	glitch_drop_a: assert property (@(posedge clock) disable iff (rst) // RL12
		!oc_s |=> !oc_filt) else $error("filter kept a dropped pulse");

	restart_len_a: assert property (@(posedge clock) disable iff (rst) // RL20
		restart_done_s |-> $past(restart_len_r) == hbg_pkg::CNT_W'(RESTART_CYC - 1))
		else $error("restart phase length wrong");

	retrip_a: assert property (@(posedge clock) disable iff (rst) // RL13
		retrip_s |=> sd_r == hbg_pkg::HBG_DISCHG) else $error("no retrip in restart");

	discharge_exit_a: assert property (@(posedge clock) disable iff (rst) // RL16
		discharge_wait_s |=> sd_r == hbg_pkg::HBG_DISCHG) else $error("discharge left early");

	restart_idle_a: assert property (@(posedge clock) disable iff (rst) // RL16
		sd_r == hbg_pkg::HBG_RESTART |=> !shutdown_timer_pin_oe)
		else $error("pin discharged in restart");

	pin_busy_a: assert property (@(posedge clock) disable iff (rst) // RL16
		shutdown_timer_pin_oe |-> sd_r != hbg_pkg::HBG_RUN)
		else $error("pin discharged while running");

	gates_off_sd_a: assert property (@(posedge clock) disable iff (rst) // RL13 RL15
		sd_r != hbg_pkg::HBG_RUN |-> low_gate_out == '0 && high_gate_out == '0)
		else $error("gate on during shutdown");

	fault_in_sd_a: assert property (@(posedge clock) disable iff (rst) // RL14 RL15
		sd_r != hbg_pkg::HBG_RUN |=> fault_flag_oe) else $error("fault free in shutdown");

	drain_data_a: assert property (@(posedge clock) disable iff (rst) // RL9 RL14
		!fault_flag_o && !shutdown_timer_pin_o) else $error("open-drain data high");

	// per channel: both-off run length, seen from the gate outputs only
	for (genvar k = 0; k < CH; k++) begin : g_gap
		logic [hbg_pkg::CNT_W-1:0] gap_r;

		always_ff @(posedge clock) begin
			if (rst || low_gate_out[k] || high_gate_out[k])
				gap_r <= '0;
			else if (gap_r != '1)
				gap_r <= gap_r + 1'b1;
		end

		// a bootstrap drop and its release with the request held steady
		sequence boot_clear_s;
			allow && boot_s[k] && !hi_s[k] && lo_s[k]
				##1 allow && !boot_s[k] && !hi_s[k] && lo_s[k];
		endsequence

		low_dead_a: assert property (@(posedge clock) disable iff (rst) // RL5
			$rose(low_gate_out[k]) |-> gap_r >= hbg_pkg::CNT_W'(hbg_pkg::DEAD_INTERVAL_CYC))
			else $error("low gate dead gap short");

		high_dead_a: assert property (@(posedge clock) disable iff (rst) // RL5
			$rose(high_gate_out[k]) |-> gap_r >= hbg_pkg::CNT_W'(hbg_pkg::DEAD_INTERVAL_CYC))
			else $error("high gate dead gap short");

		low_prompt_a: assert property (@(posedge clock) disable iff (rst) // RL6 RL2
			allow && !lo_s[k] && hi_s[k]
				&& gap_r >= hbg_pkg::CNT_W'(hbg_pkg::DEAD_INTERVAL_CYC) |=> low_gate_out[k])
			else $error("extra delay on low gate");

		pair_lock_a: assert property (@(posedge clock) disable iff (rst) // RL4
			!lo_s[k] && !hi_s[k] |=> !low_gate_out[k] && !high_gate_out[k])
			else $error("gate on with both commands low");

		boot_kill_a: assert property (@(posedge clock) disable iff (rst) // RL10
			boot_s[k] |=> !high_gate_out[k]) else $error("high gate on in boot uv");

		boot_hold_a: assert property (@(posedge clock) disable iff (rst) // RL11
			boot_clear_s |=> !high_gate_out[k]) else $error("high gate back without request");
	end
endmodule

/* rtl/hbg_pkg.sv */
// package with constants for the half-bridge gate logic
// What this block does
// RL1: enable low forces all gates low
// RL2: low command alone drives low gate
// RL3: high command alone drives high gate
// RL4: both commands low force both gates low
// RL5: dead interval before companion gate turns on
// RL6: longer command gap adds no extra delay
// RL7: main undervoltage switches off every gate
// RL8: after main undervoltage, high gated by bootstrap
// RL9: fault flag low during main undervoltage
// RL10: bootstrap undervoltage kills that channel's high gate
// RL11: high stays off until next turn-on request
// RL12: glitch filter drops short overcurrent pulses
// RL13: latch trigger forces all gates low
// RL14: trigger pulls fault low, starts pin discharge
// RL15: disable time end releases fault, outputs resume
// RL16: discharge stops when clear and pin low
// RL17: main undervoltage disables overcurrent comparator
// RL18: fault flag affects no internal behaviour
// RL19: filter time nominally 300 ns, 200 to 400
// RL20: restart phase is a programmable cycle count
// RL21: inputs synchronised; dead interval counted in cycles
package hbg_pkg;
	localparam int CLOCK_HZ            = 40_000_000;
	localparam int CLOCK_PERIOD_PS     = 1_000_000_000 / (CLOCK_HZ / 1000);
	localparam int CHANNELS            = 3;
	localparam int DEAD_INTERVAL_NS    = 200;
	localparam int DEAD_INTERVAL_CYC   = (DEAD_INTERVAL_NS * 1000 + CLOCK_PERIOD_PS - 1)
		/ CLOCK_PERIOD_PS;
	localparam int GLITCH_FILTER_NS    = 300;
	localparam int GLITCH_FILTER_CYC   = (GLITCH_FILTER_NS * 1000 + CLOCK_PERIOD_PS - 1)
		/ CLOCK_PERIOD_PS;
	localparam int RESTART_CYC_DEFAULT = 8000;
	localparam int CNT_W               = 16;
	localparam logic OUT_RESET         = 1'b0;
	typedef enum logic [2:0] {
		HBG_RUN     = 3'b001,
		HBG_DISCHG  = 3'b010,
		HBG_RESTART = 3'b100
	} hbg_sd_state_t;
endpackage

/* rtl/hbg_channel.sv */
// one half-bridge channel: decode, interlock, dead interval, bootstrap gating
`timescale 1ns/1ps
module hbg_channel #(
	parameter int DEAD_CYC = hbg_pkg::DEAD_INTERVAL_CYC
) (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic allow,
	input  wire logic low_cmd_n,
	input  wire logic high_side_cmd_n,
	input  wire logic boot_uv,
	output logic      low_gate_out,
	output logic      high_gate_out
);
	logic                      want_low;
	logic                      want_high;
	logic                      boot_block_r;
	logic                      high_req_d_r;
	logic [hbg_pkg::CNT_W-1:0] idle_cnt_r;
	logic                      dead_ok;

	assign want_low  = allow && !low_cmd_n && high_side_cmd_n; // RL1 RL2 RL4
	assign want_high = allow && !high_side_cmd_n && low_cmd_n; // RL1 RL3 RL4
	assign dead_ok   = idle_cnt_r >= hbg_pkg::CNT_W'(DEAD_CYC);

	// counts cycles with both gates off; a long command gap already fills it
	always_ff @(posedge clock) begin
		if (rst || low_gate_out || high_gate_out)
			idle_cnt_r <= '0;
		else if (!dead_ok)
			idle_cnt_r <= idle_cnt_r + 1'b1; // RL5 RL6
	end

	always_ff @(posedge clock) begin
		if (rst)
			high_req_d_r <= 1'b0;
		else
			high_req_d_r <= want_high;
	end

	// bootstrap block holds until a fresh turn-on request edge
	always_ff @(posedge clock) begin
		if (rst)
			boot_block_r <= 1'b0;
		else if (boot_uv)
			boot_block_r <= 1'b1; // RL10
		else if (want_high && !high_req_d_r)
			boot_block_r <= 1'b0; // RL11
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			low_gate_out  <= hbg_pkg::OUT_RESET;
			high_gate_out <= hbg_pkg::OUT_RESET;
		end else begin
			low_gate_out  <= want_low && (low_gate_out || dead_ok); // RL5
			high_gate_out <= want_high && !boot_uv && !(boot_block_r && high_req_d_r)
				&& (high_gate_out || dead_ok); // RL8 RL10 RL11
		end
	end

	never_both_a: assert property (@(posedge clock) disable iff (rst) // RL4
		!(low_gate_out && high_gate_out)) else $error("both gates high");
	dead_gap_a: assert property (@(posedge clock) disable iff (rst) // RL5
		$fell(low_gate_out) |-> !high_gate_out [*3]) else $error("dead gap short");
	boot_off_a: assert property (@(posedge clock) disable iff (rst) // RL10
		boot_uv |=> !high_gate_out) else $error("high on in boot uv");
endmodule

/* testbench/hbg_od_model.sv */
// timing capacitor on the shutdown pin: falls below unlatch only while discharged
`timescale 1ns/1ps
module hbg_od_model (
	input  wire logic clock,
	input  wire logic discharge,
	output logic      pin_low
);
	logic [3:0] cnt_r;
	// a few cycles of discharge before the level drops, so latch must hold meanwhile
	always_ff @(posedge clock) begin
		if (!discharge) begin
			cnt_r <= 4'h0;
		end else if (cnt_r != 4'h5) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	assign pin_low = discharge && (cnt_r == 4'h5);
endmodule

/* testbench/test_half_bridge_gate_logic.sv */
// self-checking bench for the three-channel gate logic
`timescale 1ns/1ps
module test_half_bridge_gate_logic;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       en = 1'b0;
	logic       uv = 1'b0;
	logic       oc = 1'b0;
	logic [2:0] lo_n = 3'h7;
	logic [2:0] hi_n = 3'h7;
	logic [2:0] buv = 3'h0;
	logic [2:0] lg;
	logic [2:0] hg;
	logic       fo;
	logic       foe;
	logic       po;
	logic       poe;
	logic       pin_low;
	int         fails = 0;
	int         total_checks = 0;
	int         i;
	always #12.5 clock = ~clock;
	hbg_top #(.RESTART_CYC(20)) uut (.clock(clock), .rst(rst), .enable_in(en),
		.low_cmd_n(lo_n), .high_side_cmd_n(hi_n), .main_uv_in(uv),
		.bootstrap_supply_uv(buv), .overcurrent_sense_in(oc),
		.shutdown_timer_pin_low(pin_low), .low_gate_out(lg), .high_gate_out(hg),
		.fault_flag_o(fo), .fault_flag_oe(foe), .shutdown_timer_pin_o(po),
		.shutdown_timer_pin_oe(poe));
	hbg_od_model pm (.clock(clock), .discharge(poe), .pin_low(pin_low));
	task automatic chk(input string n, input logic [5:0] e, input logic [5:0] s);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	// truth table: one command low drives its gate, both low drives none
	function automatic logic [5:0] gates(input logic e, input logic [2:0] l, input logic [2:0] h);
		return e ? {l & ~h, ~l & h} : 6'h00;
	endfunction
	task automatic conclude();
		if (fails == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'heaf5_6ede));
		step(20);
		rst = 1'b0;
		step(6);
		chk("fault idle", 6'h00, {4'h0, fo, foe});
		for (i = 0; i < 40; i++) begin
			en = ($urandom % 4) != 0;
			lo_n = 3'($urandom);
			hi_n = 3'($urandom);
			step(14);
			chk("gates", gates(en, lo_n, hi_n), {hg, lg});
		end
		en = 1'b1;
		lo_n = 3'h6;
		hi_n = 3'h7;
		step(14);
		lo_n = 3'h7;
		hi_n = 3'h6;
		step(6);
		chk("dead wait", 6'h00, {hg, lg});
		step(8);
		chk("after dead", 6'h08, {hg, lg});
		hi_n = 3'h7;
		step(14);
		hi_n = 3'h6;
		step(4);
		chk("no extra gap", 6'h08, {hg, lg});
		lo_n = 3'h6;
		hi_n = 3'h5;
		step(14);
		uv = 1'b1;
		step(6);
		chk("main uv gates", 6'h00, {hg, lg});
		chk("main uv fault", 6'h01, {5'h00, foe});
		oc = 1'b1;
		step(20);
		chk("comp off", 6'h00, {5'h00, poe});
		oc = 1'b0;
		uv = 1'b0;
		step(14);
		chk("uv end", 6'h11, {hg, lg});
		buv = 3'h2;
		step(6);
		chk("boot uv", 6'h01, {hg, lg});
		buv = 3'h0;
		step(14);
		chk("boot held", 6'h01, {hg, lg});
		hi_n = 3'h7;
		step(14);
		hi_n = 3'h5;
		step(14);
		chk("boot rearm", 6'h11, {hg, lg});
		oc = 1'b1;
		step(8);
		oc = 1'b0;
		step(6);
		chk("glitch gates", 6'h11, {hg, lg});
		chk("glitch pin", 6'h00, {5'h00, poe});
		oc = 1'b1;
		step(16);
		chk("trip gates", 6'h00, {hg, lg});
		chk("trip flags", 6'h03, {4'h0, foe, poe});
		step(10);
		chk("hold discharge", 6'h01, {5'h00, poe});
		oc = 1'b0;
		step(10);
		chk("restart gates", 6'h00, {hg, lg});
		chk("restart flags", 6'h02, {4'h0, foe, poe});
		step(25);
		chk("resume", 6'h11, {hg, lg});
		chk("released", 6'h00, {3'h0, fo, foe, po});
		conclude();
	end
endmodule
